// File: verilog/pdc_pkg.sv
// constants, modes and state codes of the programmable down-counter
// assumes one 100 MHz ref_clk; every pin but resetn and clk_en is synchronised before use
//
// What this block does
// - sixteen-bit down-counter, zero drives main output
// - latches capture preset on strobe rising edge
// - strobe low makes latches transparent
// - three mode bits select modes 0 to 7
// - trigger high: count edge reloads from latches
// - trigger low: count edge decrements counter
// - mode 0: output rises at zero, half toggles
// - modes 0-3: trigger reloads, output to rest
// - mode 1: inverted level, half toggles on fall
// - mode 2: one-period high pulse at zero
// - mode 3: one-period low pulse at zero
// - mode 4: pulse at zero, trigger freezes count
// - mode 4: no reload until zero reached
// - only mode 7 reloads itself after zero
// - zero preset keeps the counter idle
// - mode 5: like mode 4, low pulse
// - mode 6: high while counting, retrigger reloads
// - mode 6: pulse N-1 periods, no preset one
// - mode 7: pulse, toggle and reload at zero
`default_nettype none

package pdc_pkg;

    // ==========================================================
    // widths and synchroniser depth
    localparam int CNT_W       = 16;
    localparam int MODE_W      = 3;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // mode codes, top select bit most significant
    localparam logic [MODE_W-1:0] MODE_LEVEL      = 3'h0;
    localparam logic [MODE_W-1:0] MODE_LEVEL_INV  = 3'h1;
    localparam logic [MODE_W-1:0] MODE_PULSE      = 3'h2;
    localparam logic [MODE_W-1:0] MODE_PULSE_INV  = 3'h3;
    localparam logic [MODE_W-1:0] MODE_HOLD       = 3'h4;
    localparam logic [MODE_W-1:0] MODE_HOLD_INV   = 3'h5;
    localparam logic [MODE_W-1:0] MODE_ONE_SHOT   = 3'h6;
    localparam logic [MODE_W-1:0] MODE_FREQ_GEN   = 3'h7;

    // ==========================================================
    // reset values and count constants
    localparam logic [CNT_W-1:0]  COUNT_ZERO      = 16'h0000;
    localparam logic [CNT_W-1:0]  COUNT_ONE       = 16'h0001;
    localparam logic [CNT_W-1:0]  LATCH_RESET     = 16'h0000;
    localparam logic              HALF_RESET      = 1'b0;
    localparam logic              MAIN_RESET      = 1'b0;

    // ==========================================================
    // sequencer states, gray along idle-loaded-count-done
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LOADED = 2'b01,
        ST_COUNT  = 2'b11,
        ST_DONE   = 2'b10
    } pdc_state_e;

endpackage

`default_nettype wire

// File: verilog/pdc_latch_if.sv
// carrier between the preset latch and the counter core
// assumes both ends run on the same ref_clk
`timescale 1ns/1ps
`default_nettype none

interface pdc_latch_if;
    logic [pdc_pkg::CNT_W-1:0] value;
    logic                      is_zero;

    modport source (
        output value,
        output is_zero
    );
    modport sink (
        input  value,
        input  is_zero
    );
endinterface

`default_nettype wire

// File: verilog/pdc_preset_latch.sv
// preset data latches with pin synchronisers
// assumes preset and strobe come from outside the ref_clk domain
`timescale 1ns/1ps
`default_nettype none

module pdc_preset_latch (
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire logic                      clk_en,
    input  wire logic [pdc_pkg::CNT_W-1:0] preset_in,
    input  wire logic                      write_strobe_n,
    pdc_latch_if.source                    lat
);
    import pdc_pkg::*;

    // ==========================================================
    // synchronisers, first stage read only by the second
    logic [CNT_W-1:0] preset_meta;
    logic [CNT_W-1:0] preset_sync;
    logic             strobe_meta_n;
    logic             strobe_sync_n;
    logic [CNT_W-1:0] value;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            preset_meta   <= LATCH_RESET;
            preset_sync   <= LATCH_RESET;
            strobe_meta_n <= 1'b1;
            strobe_sync_n <= 1'b1;
        end else if (clk_en) begin
            preset_meta   <= preset_in;
            preset_sync   <= preset_meta;
            strobe_meta_n <= write_strobe_n;
            strobe_sync_n <= strobe_meta_n;
        end
    end

    // ==========================================================
    // transparent while low; on the rise the last value stays held
    // data and strobe share the same delay, so the held word is the
    // one present at the strobe's rising edge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            value <= LATCH_RESET;
        end else if (clk_en && !strobe_sync_n) begin
            value <= preset_sync;
        end
    end

    assign lat.value   = value;
    assign lat.is_zero = (value == COUNT_ZERO);

endmodule

`default_nettype wire

// File: verilog/pdc_counter.sv
// programmable down-counter core: eight timing modes on one count clock
// assumes count_clock, trigger_in, master_clear and mode_select are pins;
// count_clock high and low phases each last at least two ref_clk periods
`timescale 1ns/1ps
`default_nettype none

module pdc_counter (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic                       clk_en,
    input  wire logic [pdc_pkg::CNT_W-1:0]  preset_in,
    input  wire logic                       write_strobe_n,
    input  wire logic [pdc_pkg::MODE_W-1:0] mode_select,
    input  wire logic                       trigger_in,
    input  wire logic                       master_clear,
    input  wire logic                       count_clock,
    output logic                            timer_out,
    output logic                            half_rate_out,
    output logic [pdc_pkg::CNT_W-1:0]       count_value,
    output logic [pdc_pkg::CNT_W-1:0]       latch_value
);
    import pdc_pkg::*;

    // ==========================================================
    // preset latches
    pdc_latch_if lat ();

    pdc_preset_latch u_latch (
        .ref_clk        (ref_clk),
        .resetn         (resetn),
        .clk_en         (clk_en),
        .preset_in      (preset_in),
        .write_strobe_n (write_strobe_n),
        .lat            (lat.source)
    );

    // ==========================================================
    // pin synchronisers, one pair of flops per pin bit
    // mode and trigger share the count clock's delay, so each is seen
    // in step with the count edge that it qualifies
    localparam int PIN_N = MODE_W + 3;

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;

    assign pin_raw = {mode_select, master_clear, trigger_in, count_clock};

    generate
        for (genvar i = 0; i < PIN_N; i++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end else if (clk_en) begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                end
            end
        end
    endgenerate

    logic              cp_level;
    logic              trig;
    logic              mclr;
    logic [MODE_W-1:0] mode;
    logic              cp_prev;
    logic              cp_rise;

    assign cp_level = pin_sync[0];
    assign trig     = pin_sync[1];
    assign mclr     = pin_sync[2];
    assign mode     = pin_sync[PIN_N-1:3];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cp_prev <= 1'b0;
        end else if (clk_en) begin
            cp_prev <= cp_level;
        end
    end

    // all counter action but master clear and the ST_IDLE rest level of main_q happens on a count-clock rising edge
    // sampled rather than used as a clock: one clock domain, at the cost
    // of both count-clock phases having to last two ref_clk periods
    assign cp_rise = cp_level & ~cp_prev;

    // ==========================================================
    // mode decode
    // rest_high: output level between events, modes 1, 3 and 5
    // no default item: three bits cover all eight codes
    logic rest_high;
    logic pulse_mode;
    logic hold_mode;
    logic retrig_mode;
    logic auto_mode;

    always_comb begin
        rest_high   = 1'b0;
        pulse_mode  = 1'b0;
        hold_mode   = 1'b0;
        retrig_mode = 1'b0;
        auto_mode   = 1'b0;
        unique case (mode)
            MODE_LEVEL: begin
            end
            MODE_LEVEL_INV: begin
                rest_high = 1'b1;
            end
            MODE_PULSE: begin
                pulse_mode = 1'b1;
            end
            MODE_PULSE_INV: begin
                rest_high  = 1'b1;
                pulse_mode = 1'b1;
            end
            MODE_HOLD: begin
                pulse_mode = 1'b1;
                hold_mode  = 1'b1;
            end
            MODE_HOLD_INV: begin
                rest_high  = 1'b1;
                pulse_mode = 1'b1;
                hold_mode  = 1'b1;
            end
            MODE_ONE_SHOT: begin
                retrig_mode = 1'b1;
            end
            MODE_FREQ_GEN: begin
                pulse_mode = 1'b1;
                auto_mode  = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // state registers
    pdc_state_e       state;
    pdc_state_e       next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             main_q;
    logic             next_main_q;
    logic             half_q;
    // set for the one count period in which a pulse is out
    logic             pulse_on;
    logic             next_pulse_on;
    logic             terminal;
    logic             dec_step;

    // ==========================================================
    // next-state logic for one count-clock edge
    always_comb begin
        next_state    = state;
        next_count    = count;
        next_main_q   = main_q;
        next_pulse_on = 1'b0;
        terminal      = 1'b0;
        dec_step      = 1'b0;

        // a pulse lasts exactly one count period
        if (pulse_on) begin
            next_main_q = rest_high;
        end
        if (state == ST_IDLE) begin
            next_main_q = rest_high;
        end

        // trigger outranks counting, except where a mode refuses reload
        if (trig) begin
            if (hold_mode && state == ST_COUNT) begin
                next_main_q = main_q;
            end else if (retrig_mode && state == ST_COUNT) begin
                // retrigger restarts the count but leaves the output alone
                next_count = lat.value;
            end else begin
                next_count  = lat.value;
                next_main_q = rest_high;
                next_state  = ST_LOADED;
            end
        end else begin
            unique case (state)
                ST_IDLE, ST_DONE: begin
                    // waits for a new trigger pulse
                    next_state = state;
                end
                ST_LOADED: begin
                    if (count == COUNT_ZERO) begin
                        next_state = ST_IDLE;
                    end else begin
                        dec_step   = 1'b1;
                        next_state = ST_COUNT;
                        if (retrig_mode) begin
                            next_main_q = 1'b1;
                        end
                    end
                end
                ST_COUNT: begin
                    if (count == COUNT_ZERO) begin
                        next_state = ST_IDLE;
                    end else begin
                        dec_step = 1'b1;
                    end
                end
            endcase
        end

        // terminal is the step from one to zero; zero itself is never
        // decremented, so the counter cannot wrap to all ones
        if (dec_step) begin
            next_count = count - COUNT_ONE;
            terminal   = (count == COUNT_ONE);
        end

        if (terminal) begin
            next_pulse_on = pulse_mode;
            if (retrig_mode) begin
                next_main_q = 1'b0;
            end else begin
                next_main_q = ~rest_high;
            end
            if (auto_mode) begin
                next_count = lat.value;
                next_state = lat.is_zero ? ST_IDLE : ST_COUNT;
            end else begin
                next_state = ST_DONE;
            end
        end
    end

    // ==========================================================
    // sequencer
    // master clear acts on every ref_clk it is seen, not on count edges
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            if (mclr) begin
                state <= ST_IDLE;
            end else if (cp_rise) begin
                state <= next_state;
            end
        end
    end

    // ==========================================================
    // counter
    // held between count edges, so count_value stands a full count period
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            count <= COUNT_ZERO;
        end else if (clk_en) begin
            if (mclr) begin
                count <= COUNT_ZERO;
            end else if (cp_rise) begin
                count <= next_count;
            end
        end
    end

    // ==========================================================
    // main output and pulse timer
    // under reset the mode is unknown, so the output starts low and
    // takes its rest level three cycles after release, once the mode is synchronised
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            main_q   <= MAIN_RESET;
            pulse_on <= 1'b0;
        end else if (clk_en) begin
            if (mclr) begin
                main_q   <= rest_high;
                pulse_on <= 1'b0;
            end else if (cp_rise) begin
                main_q   <= next_main_q;
                pulse_on <= next_pulse_on;
            end else if (state == ST_IDLE) begin
                main_q   <= rest_high;
            end
        end
    end

    // ==========================================================
    // half-rate output: flips on every terminal count
    // a clear in the same cycle as a terminal count wins over the flip
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            half_q <= HALF_RESET;
        end else if (clk_en) begin
            if (mclr) begin
                half_q <= HALF_RESET;
            end else if (cp_rise && terminal) begin
                half_q <= ~half_q;
            end
        end
    end

    // every output straight from a flop, so no decode glitch reaches a pin
    assign timer_out     = main_q;
    assign half_rate_out = half_q;
    assign count_value   = count;
    assign latch_value   = lat.value;

endmodule

`default_nettype wire

// File: tb/pdc_cp_source.sv
// count clock source standing in for the host logic on the far side
// assumes the bench raises req by non-blocking assignment at a falling edge
`timescale 1ns/1ps
`default_nettype none

module pdc_cp_source (
    input  wire logic ref_clk,
    input  wire logic req,
    output logic      count_clock,
    output logic      busy
);
    logic [3:0] phase;

    initial phase = 4'h0;

    // ==========================================================
    // one count period per request
    // phases of 8 ref cycles, well over the 2 the pin sampler needs
    always @(negedge ref_clk) begin
        if (phase != 4'h0) begin
            phase <= phase - 4'h1;
        end else if (req) begin
            phase <= 4'hF;
        end
    end

    // parked low between requests, never free running
    assign count_clock = phase[3];
    assign busy        = (phase != 4'h0);
endmodule

`default_nettype wire

// File: tb/pdc_counter_properties.sv
// timing checks on the ports of the programmable down-counter
// assumes pins reach the core three ref_clk edges after they change
`timescale 1ns/1ps
`default_nettype none

module pdc_counter_properties (
    input wire logic                       ref_clk,
    input wire logic                       resetn,
    input wire logic                       clk_en,
    input wire logic [pdc_pkg::CNT_W-1:0]  preset_in,
    input wire logic                       write_strobe_n,
    input wire logic [pdc_pkg::MODE_W-1:0] mode_select,
    input wire logic                       trigger_in,
    input wire logic                       master_clear,
    input wire logic                       count_clock,
    input wire logic                       timer_out,
    input wire logic                       half_rate_out,
    input wire logic [pdc_pkg::CNT_W-1:0]  count_value,
    input wire logic [pdc_pkg::CNT_W-1:0]  latch_value
);
    import pdc_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // mode must have settled through the pin synchronisers
    sequence m7_steady;
        (mode_select == MODE_FREQ_GEN) [*8];
    endsequence

    AST_RESET_VALUES: assert property (disable iff (1'b0) !resetn |=>
        timer_out == MAIN_RESET && half_rate_out == HALF_RESET && count_value == COUNT_ZERO)
        else $error("outputs not cleared by reset");
    AST_CLEAR_REST: assert property ((master_clear && $stable(mode_select)) [*6] |->
        count_value == COUNT_ZERO && half_rate_out == HALF_RESET && timer_out ==
        (mode_select == MODE_LEVEL_INV || mode_select == MODE_PULSE_INV ||
         mode_select == MODE_HOLD_INV))
        else $error("master clear did not restore rest state");
    AST_HALF_AT_TERMINAL: assert property ((!master_clear) [*5] ##0
        $changed(half_rate_out) |-> $past(count_value) == COUNT_ONE)
        else $error("half rate output moved away from terminal count");
    AST_COUNT_STEP: assert property ($changed(count_value) |->
        count_value == $past(count_value) - COUNT_ONE ||
        count_value == $past(latch_value) || count_value == COUNT_ZERO)
        else $error("counter moved by other than a step or a reload");
    AST_HOLD_FREEZE: assert property ((mode_select == MODE_HOLD && trigger_in) [*8] ##0
        (count_value != COUNT_ZERO && count_value != latch_value) |=> $stable(count_value))
        else $error("count hold mode changed a frozen count");
    AST_LEVEL_AT_ZERO: assert property ((mode_select == MODE_LEVEL) [*8] ##0
        $rose(timer_out) |-> count_value == COUNT_ZERO && $changed(half_rate_out))
        else $error("level output rose away from zero count");
    AST_ONE_SHOT_END: assert property ((mode_select == MODE_ONE_SHOT) [*8] ##0
        $fell(timer_out) |-> count_value == COUNT_ZERO)
        else $error("one shot ended away from zero count");
    AST_FREQ_RELOAD: assert property (m7_steady ##0 $rose(timer_out) |->
        count_value == $past(latch_value) && $past(count_value) == COUNT_ONE)
        else $error("frequency mode pulse without reload");
    AST_LATCH_FOLLOW: assert property ((!write_strobe_n && $stable(preset_in)) [*5] |->
        latch_value == preset_in)
        else $error("latch not transparent while strobe low");
    AST_LATCH_HOLD: assert property (write_strobe_n [*5] |=> $stable(latch_value))
        else $error("latch changed while strobe high");

    COV_FREQ_PULSE: cover property (m7_steady ##0 $rose(timer_out));
    COV_HOLD: cover property ((mode_select == MODE_HOLD && trigger_in) [*8]);
    COV_ONE_SHOT: cover property ((mode_select == MODE_ONE_SHOT) [*8] ##0 $fell(timer_out));
endmodule

bind pdc_counter pdc_counter_properties u_props (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .preset_in(preset_in),
    .write_strobe_n(write_strobe_n), .mode_select(mode_select), .trigger_in(trigger_in),
    .master_clear(master_clear), .count_clock(count_clock), .timer_out(timer_out),
    .half_rate_out(half_rate_out), .count_value(count_value), .latch_value(latch_value)
);

`default_nettype wire

// File: tb/test_programmable_down_counter.sv
// self-checking bench of the programmable down-counter
// assumes the counter core, its package and the count clock source model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module test_programmable_down_counter;
    import pdc_pkg::*;

    logic        ref_clk, resetn, clk_en, write_strobe_n, trigger_in;
    logic        master_clear, count_clock, timer_out, half_rate_out, cp_req, cp_busy;
    logic [15:0] preset_in, count_value, latch_value;
    logic [2:0]  mode_select;
    int          fail_count, tests_run;

    pdc_cp_source u_cp (.ref_clk(ref_clk), .req(cp_req), .count_clock(count_clock),
                        .busy(cp_busy));
    pdc_counter dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .preset_in(preset_in), .write_strobe_n(write_strobe_n), .mode_select(mode_select),
        .trigger_in(trigger_in), .master_clear(master_clear), .count_clock(count_clock),
        .timer_out(timer_out), .half_rate_out(half_rate_out), .count_value(count_value),
        .latch_value(latch_value));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // access tasks, all driving at the falling edge
    function automatic logic rest(input logic [2:0] m);
        return (m == MODE_LEVEL_INV) || (m == MODE_PULSE_INV) || (m == MODE_HOLD_INV);
    endfunction

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // one count clock period, then let the three-edge pin lag land
    task automatic tick();
        cp_req <= 1'b1;
        @(negedge ref_clk);
        cp_req <= 1'b0;
        wait_n(2);
        while (cp_busy) @(negedge ref_clk);
        wait_n(2);
    endtask

    task automatic trig(input logic t);
        trigger_in = t;
        wait_n(4);
    endtask

    // preset held valid well past the strobe rise
    task automatic load(input logic [15:0] v);
        write_strobe_n = 1'b0;
        preset_in = v;
        wait_n(6);
        `CHK(latch_value, v)
        write_strobe_n = 1'b1;
        wait_n(5);
        preset_in = ~v;
        wait_n(6);
        `CHK(latch_value, v)
    endtask

    task automatic set_mode(input logic [2:0] m);
        master_clear = 1'b1;
        mode_select = m;
        wait_n(8);
        `CHK({count_value, half_rate_out, timer_out}, {16'h0000, 1'b0, rest(m)})
        master_clear = 1'b0;
        wait_n(4);
    endtask

    task automatic run_mode(input logic [2:0] m);
        logic f;
        logic lvl;
        logic os;
        logic r;
        f = (m == MODE_FREQ_GEN);
        lvl = (m == MODE_LEVEL) || (m == MODE_LEVEL_INV);
        os = (m == MODE_ONE_SHOT);
        r = rest(m);
        set_mode(m);
        trig(1'b1);
        tick();
        `CHK({count_value, timer_out}, {16'h0003, r})
        trig(1'b0);
        tick();
        `CHK({count_value, timer_out}, {16'h0002, os | r})
        tick();
        `CHK(count_value, 16'h0001)
        tick();
        `CHK(count_value, f ? 16'h0003 : 16'h0000)
        `CHK(timer_out, os ? 1'b0 : ~r)
        `CHK(half_rate_out, 1'b1)
        tick();
        `CHK(count_value, f ? 16'h0002 : 16'h0000)
        `CHK(timer_out, lvl ^ r)
        trig(1'b1);
        tick();
        `CHK({count_value, timer_out}, {16'h0003, r})
        trig(1'b0);
        $display("mode %0d sequence done", m);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {resetn, write_strobe_n, trigger_in, master_clear, cp_req} = 5'b01000;
        clk_en = 1'b1;
        preset_in = 16'h0000;
        mode_select = 3'h0;
        fail_count = 0;
        tests_run = 0;
        wait_n(8);
        resetn = 1'b1;
        wait_n(4);
        `CHK({count_value, latch_value, half_rate_out}, {32'h0, 1'b0})
        load(16'h0003);
        for (int i = 0; i < 8; i++) begin
            run_mode(3'(i));
        end
        load(16'h0005);
        set_mode(MODE_HOLD);
        trig(1'b1);
        tick();
        trig(1'b0);
        tick();
        tick();
        trig(1'b1);
        tick();
        tick();
        `CHK(count_value, 16'h0003)
        trig(1'b0);
        tick();
        `CHK(count_value, 16'h0002)
        $display("count hold done");
        // preset of one never used in this mode
        set_mode(MODE_ONE_SHOT);
        trig(1'b1);
        tick();
        trig(1'b0);
        tick();
        trig(1'b1);
        tick();
        `CHK({count_value, timer_out}, {16'h0005, 1'b1})
        trig(1'b0);
        // a count period while frozen must leave no trace
        clk_en = 1'b0;
        tick();
        clk_en = 1'b1;
        wait_n(4);
        `CHK({count_value, timer_out}, {16'h0005, 1'b1})
        $display("one shot retrigger done");
        load(16'h0000);
        set_mode(MODE_LEVEL);
        trig(1'b1);
        tick();
        trig(1'b0);
        tick();
        tick();
        `CHK({count_value, timer_out, half_rate_out}, {16'h0000, 2'b00})
        $display("zero preset done");
        stop_test();
    end

    // full run needs about 1500 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule

`default_nettype wire
